// *** hw/mcuop_pkg.sv ***
// Purpose: shared constants for the move/logic/rotate/return execute unit
// Assumes: 8-bit data, 12-bit program counter, internal opcode encoding
// Notes: opcode values are internal codes, not the device's binary encoding
package mcuop_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 12;
   localparam int ADDR_W = 8;
   localparam int STACK_DEPTH = 6;
   localparam int SP_W = 3;
   localparam int OP_W = 5;
   localparam int MSB = 7;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [11:0] PC_RESET = 12'h000;
   localparam logic [11:0] PC_STEP = 12'h001;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [2:0] SP_STEP = 3'h1;
   // ---------------------------------------------------------------
   // operation codes
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NOP = 5'h00,
      OP_MOV_IMM = 5'h01,
      OP_MOV_TO_MEM = 5'h02,
      OP_OR_MEM = 5'h03,
      OP_OR_IMM = 5'h04,
      OP_OR_TO_MEMORY = 5'h05,
      OP_RET = 5'h06,
      OP_RET_IMM = 5'h07,
      OP_RETURN_FROM_INTERRUPT = 5'h08,
      OP_ROTATE_LEFT = 5'h09,
      OP_ROTATE_LEFT_TO_ACC = 5'h0A,
      OP_ROTATE_LEFT_THROUGH_CARRY = 5'h0B,
      OP_ROTATE_LEFT_CARRY_TO_ACC = 5'h0C,
      OP_ROTATE_RIGHT = 5'h0D,
      OP_ROTATE_RIGHT_TO_ACC = 5'h0E,
      OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h0F,
      OP_ROTATE_RIGHT_CARRY_TO_ACC = 5'h10,
      OP_SUBTRACT_WITH_BORROW = 5'h11,
      OP_SUBTRACT_BORROW_TO_MEMORY = 5'h12,
      OP_DECREMENT_SKIP_IF_ZERO = 5'h13,
      OP_DECREMENT_TO_ACC_SKIP_IF_ZERO = 5'h14,
      OP_CALL = 5'h15
   } mcuop_op_e;
   // ---------------------------------------------------------------
   // execute states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_EXEC = 2'b01,
      ST_DUMMY = 2'b10
   } mcuop_state_e;
endpackage

// *** hw/mcuop_exec.sv ***
// Purpose: execute unit for moves, OR, returns, rotates, subtract, dec-skip
// Assumes: one instruction presented per cycle with instrValid; memory is internal
// Notes: dummy cycle inserted for returns and for taken decrement skips
// Notes on behaviour
// - move immediate loads constant into accumulator
// - store copies accumulator into memory, acc unchanged
// - no-op only advances program counter by one
// - OR memory into accumulator
// - OR immediate into accumulator
// - OR memory with acc, result to memory
// - return pops PC, takes two cycles
// - return-with-constant pops PC, loads accumulator
// - interrupt return pops PC, sets interrupt enable
// - rotate memory left, bit7 to bit0
// - rotate left into accumulator, memory kept
// - rotate memory left through carry
// - rotate left through carry into accumulator
// - rotate memory right, bit0 to bit7
// - rotate right into accumulator, memory kept
`timescale 1ns/100ps
`default_nettype none
module mcuop_exec
   import mcuop_pkg::*;
#(
   parameter int MEM_DEPTH = 160
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // instruction input
   input wire logic instrValid,
   input wire logic [OP_W-1:0] instrOp,
   input wire logic [ADDR_W-1:0] instrAddr,
   input wire logic [DATA_W-1:0] instrImm,
   input wire logic [PC_W-1:0] instrTarget,
   // handshake
   output logic instrReady,
   output logic discardNext,
   // architectural state view
   output logic [DATA_W-1:0] acc,
   output logic [PC_W-1:0] pc,
   output logic carryFlag,
   output logic zeroFlag,
   output logic auxCarryFlag,
   output logic overflowFlag,
   output logic global_interrupt_enable,
   // interrupt side: clears enable on interrupt entry, unless an interrupt return executes in the same cycle
   input wire logic intTaken
);
   // ---------------------------------------------------------------
   // reset synchroniser
   // ---------------------------------------------------------------
   logic rstMeta_r, rstSync_r;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   // ---------------------------------------------------------------
   // state and storage
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic [PC_W-1:0] stack [STACK_DEPTH];
   logic [SP_W-1:0] sp_r;
   logic [DATA_W-1:0] acc_r;
   logic [PC_W-1:0] pc_r;
   logic c_r, z_r, ac_r, ov_r, gie_r;
   mcuop_state_e state_r;

   mcuop_op_e op;
   assign op = mcuop_op_e'(instrOp);
   logic exec;
   assign exec = instrValid && (state_r == ST_EXEC);
   assign instrReady = (state_r == ST_EXEC);

   logic [DATA_W-1:0] memVal;
   assign memVal = (32'(instrAddr) < MEM_DEPTH) ? mem[instrAddr] : ZERO_BYTE;

   // ---------------------------------------------------------------
   // datapath
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] result;
   logic wrAcc, wrMem, wrCarry, newCarry, wrArith, isPop, isSkip;
   logic [DATA_W:0] sum;
   logic [4:0] lowSum;
   logic [DATA_W-1:0] memInv;
   logic [DATA_W-1:0] decVal;
   assign memInv = ~memVal;
   assign sum = {1'b0, acc_r} + {1'b0, memInv} + {8'h00, c_r};
   assign lowSum = {1'b0, acc_r[3:0]} + {1'b0, memInv[3:0]} + {4'h0, c_r};
   assign decVal = memVal - ONE_BYTE;

   always_comb begin
      result = acc_r;
      wrAcc = 1'b0;
      wrMem = 1'b0;
      wrCarry = 1'b0;
      newCarry = c_r;
      wrArith = 1'b0;
      isPop = 1'b0;
      isSkip = 1'b0;
      case (op)
         OP_NOP: begin
         end
         OP_MOV_IMM: begin
            result = instrImm;
            wrAcc = 1'b1;
         end
         OP_MOV_TO_MEM: begin
            result = acc_r;
            wrMem = 1'b1;
         end
         OP_OR_MEM: begin
            result = acc_r | memVal;
            wrAcc = 1'b1;
         end
         OP_OR_IMM: begin
            result = acc_r | instrImm;
            wrAcc = 1'b1;
         end
         OP_OR_TO_MEMORY: begin
            result = acc_r | memVal;
            wrMem = 1'b1;
         end
         OP_RET, OP_RETURN_FROM_INTERRUPT: begin
            isPop = 1'b1;
         end
         OP_RET_IMM: begin
            isPop = 1'b1;
            result = instrImm;
            wrAcc = 1'b1;
         end
         OP_ROTATE_LEFT: begin
            result = {memVal[MSB-1:0], memVal[MSB]};
            wrMem = 1'b1;
         end
         OP_ROTATE_LEFT_TO_ACC: begin
            result = {memVal[MSB-1:0], memVal[MSB]};
            wrAcc = 1'b1;
         end
         OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_LEFT_CARRY_TO_ACC: begin
            result = {memVal[MSB-1:0], c_r};
            newCarry = memVal[MSB];
            wrCarry = 1'b1;
            wrMem = (op == OP_ROTATE_LEFT_THROUGH_CARRY);
            wrAcc = (op == OP_ROTATE_LEFT_CARRY_TO_ACC);
         end
         OP_ROTATE_RIGHT: begin
            result = {memVal[0], memVal[MSB:1]};
            wrMem = 1'b1;
         end
         OP_ROTATE_RIGHT_TO_ACC: begin
            result = {memVal[0], memVal[MSB:1]};
            wrAcc = 1'b1;
         end
         OP_ROTATE_RIGHT_THROUGH_CARRY, OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
            result = {c_r, memVal[MSB:1]};
            newCarry = memVal[0];
            wrCarry = 1'b1;
            wrMem = (op == OP_ROTATE_RIGHT_THROUGH_CARRY);
            wrAcc = (op == OP_ROTATE_RIGHT_CARRY_TO_ACC);
         end
         OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_BORROW_TO_MEMORY: begin
            result = sum[DATA_W-1:0];
            newCarry = sum[DATA_W];
            wrCarry = 1'b1;
            wrArith = 1'b1;
            wrAcc = (op == OP_SUBTRACT_WITH_BORROW);
            wrMem = (op == OP_SUBTRACT_BORROW_TO_MEMORY);
         end
         OP_DECREMENT_SKIP_IF_ZERO, OP_DECREMENT_TO_ACC_SKIP_IF_ZERO: begin
            result = decVal;
            isSkip = (decVal == ZERO_BYTE);
            wrMem = (op == OP_DECREMENT_SKIP_IF_ZERO);
            wrAcc = (op == OP_DECREMENT_TO_ACC_SKIP_IF_ZERO);
         end
         default: begin
         end
      endcase
   end

   // ---------------------------------------------------------------
   // accumulator and memory
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         acc_r <= ACC_RESET;
      end else if (exec && wrAcc) begin
         acc_r <= result;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (exec && wrMem && (32'(instrAddr) < MEM_DEPTH)) begin
         mem[instrAddr] <= result;
      end
   end

   // ---------------------------------------------------------------
   // flags
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         c_r <= 1'b0;
         z_r <= 1'b0;
         ac_r <= 1'b0;
         ov_r <= 1'b0;
      end else if (exec) begin
         if (wrCarry) begin
            c_r <= newCarry;
         end
         if (wrArith) begin
            z_r <= (sum[DATA_W-1:0] == ZERO_BYTE);
            ac_r <= lowSum[4];
            ov_r <= (acc_r[MSB] == memInv[MSB]) && (sum[MSB] != acc_r[MSB]);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         gie_r <= 1'b0;
      end else if (exec && op == OP_RETURN_FROM_INTERRUPT) begin
         gie_r <= 1'b1;
      end else if (intTaken) begin
         gie_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // program counter, stack and cycle control
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         pc_r <= PC_RESET;
         sp_r <= '0;
         state_r <= ST_EXEC;
      end else begin
         case (state_r)
            ST_EXEC: begin
               if (exec) begin
                  if (isPop) begin
                     pc_r <= stack[sp_r - SP_STEP];
                     sp_r <= sp_r - SP_STEP;
                     state_r <= ST_DUMMY;
                  end else if (op == OP_CALL) begin
                     stack[sp_r] <= pc_r + PC_STEP;
                     sp_r <= (sp_r == SP_W'(STACK_DEPTH - 1)) ? '0 : sp_r + SP_STEP;
                     pc_r <= instrTarget;
                     state_r <= ST_DUMMY;
                  end else begin
                     pc_r <= pc_r + PC_STEP;
                     if (isSkip) begin
                        state_r <= ST_DUMMY;
                     end
                  end
               end
            end
            ST_DUMMY: begin
               state_r <= ST_EXEC;
            end
            default: begin
               state_r <= ST_EXEC;
            end
         endcase
      end
   end

   logic skipPending_r;
   always_ff @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         skipPending_r <= 1'b0;
      end else begin
         skipPending_r <= exec && isSkip;
      end
   end

   assign discardNext = skipPending_r;
   assign acc = acc_r;
   assign pc = pc_r;
   assign carryFlag = c_r;
   assign zeroFlag = z_r;
   assign auxCarryFlag = ac_r;
   assign overflowFlag = ov_r;
   assign global_interrupt_enable = gie_r;
endmodule // mcuop_exec
`default_nettype wire

// *** bench/mcuop_exec_properties.sv ***
// Purpose: port-level checks for mcuop_exec
// Assumes: one clock, instruction taken on instrValid and instrReady
// Notes: memory is internal, so only acc, pc, carry, interrupt enable, instrReady and discardNext are related here
`timescale 1ns/100ps
`default_nettype none
module mcuop_exec_properties
   import mcuop_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // watched ports
   input wire logic instrValid,
   input wire logic [OP_W-1:0] instrOp,
   input wire logic [DATA_W-1:0] instrImm,
   input wire logic instrReady,
   input wire logic discardNext,
   input wire logic [DATA_W-1:0] acc,
   input wire logic [PC_W-1:0] pc,
   input wire logic carryFlag,
   input wire logic global_interrupt_enable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire logic taken;
   assign taken = instrValid && instrReady;
   // one refused cycle, then ready again
   sequence s_dummy;
      !instrReady ##1 instrReady;
   endsequence
   property p_mov_imm;
      taken && instrOp == OP_MOV_IMM |=> acc == $past(instrImm);
   endproperty
   a_mov_imm: assert property (p_mov_imm) else $error("move immediate acc wrong");
   property p_store;
      taken && instrOp == OP_MOV_TO_MEM |=> $stable(acc);
   endproperty
   a_store: assert property (p_store) else $error("store changed acc");
   property p_nop;
      taken && instrOp == OP_NOP |=> $stable(acc) && $stable(carryFlag) && pc == $past(pc) + PC_STEP;
   endproperty
   a_nop: assert property (p_nop) else $error("no-op changed state");
   property p_or_imm;
      taken && instrOp == OP_OR_IMM |=> acc == ($past(acc) | $past(instrImm));
   endproperty
   a_or_imm: assert property (p_or_imm) else $error("or immediate acc wrong");
   property p_ret;
      taken && instrOp == OP_RET |=> s_dummy;
   endproperty
   a_ret: assert property (p_ret) else $error("return not two cycles");
   property p_ret_imm;
      taken && instrOp == OP_RET_IMM |=> acc == $past(instrImm) ##0 s_dummy;
   endproperty
   a_ret_imm: assert property (p_ret_imm) else $error("return with constant wrong");
   property p_return_from_interrupt;
      taken && instrOp == OP_RETURN_FROM_INTERRUPT |=> global_interrupt_enable ##0 s_dummy;
   endproperty
   a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("interrupt return enable wrong");
   property p_rot_keep;
      taken && instrOp inside {OP_ROTATE_LEFT, OP_ROTATE_RIGHT} |=> $stable(acc) && $stable(carryFlag);
   endproperty
   a_rot_keep: assert property (p_rot_keep) else $error("memory rotate touched acc");
   property p_skip;
      $rose(discardNext) |-> !instrReady ##1 !discardNext;
   endproperty
   a_skip: assert property (p_skip) else $error("skip pulse or dummy wrong");
   property p_refused;
      !instrReady |=> $stable(acc) && $stable(pc);
   endproperty
   a_refused: assert property (p_refused) else $error("dummy cycle changed state");
endmodule // mcuop_exec_properties
bind mcuop_exec mcuop_exec_properties u_props (.sys_clk(sys_clk), .rstn(rstn),
   .instrValid(instrValid), .instrOp(instrOp), .instrImm(instrImm), .instrReady(instrReady),
   .discardNext(discardNext), .acc(acc), .pc(pc), .carryFlag(carryFlag),
   .global_interrupt_enable(global_interrupt_enable));
`default_nettype wire

// *** bench/mcuop_exec_tb.sv ***
// Purpose: self-checking bench for mcuop_exec
// Assumes: inputs driven 1 ns after the rising edge
// Notes: memory is read by clearing acc and or-ing the byte in
`timescale 1ns/100ps
`default_nettype none
module mcuop_exec_tb
   import mcuop_pkg::*;
();
   localparam int DEPTH = 160;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic instrValid = 1'b0;
   logic [OP_W-1:0] instrOp = 5'h00;
   logic [ADDR_W-1:0] instrAddr = 8'h00;
   logic [DATA_W-1:0] instrImm = 8'h00;
   logic [PC_W-1:0] instrTarget = 12'h000;
   logic intTaken = 1'b0;
   logic instrReady, discardNext, carryFlag, zeroFlag, auxCarryFlag, overflowFlag;
   logic global_interrupt_enable;
   logic [DATA_W-1:0] acc;
   logic [PC_W-1:0] pc;
   int mismatches = 0;
   int total_checks = 0;
   mcuop_exec #(.MEM_DEPTH(DEPTH)) dut (.sys_clk(sys_clk), .rstn(rstn),
      .instrValid(instrValid), .instrOp(instrOp), .instrAddr(instrAddr),
      .instrImm(instrImm), .instrTarget(instrTarget), .instrReady(instrReady),
      .discardNext(discardNext), .acc(acc), .pc(pc), .carryFlag(carryFlag),
      .zeroFlag(zeroFlag), .auxCarryFlag(auxCarryFlag), .overflowFlag(overflowFlag),
      .global_interrupt_enable(global_interrupt_enable), .intTaken(intTaken));
   initial forever #4 sys_clk = ~sys_clk;
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chkv(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkf(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   // holds the request until the edge that takes it
   task automatic ex(input mcuop_op_e op, input logic [7:0] ad, input logic [7:0] imm);
      int n;
      instrValid = 1'b1;
      instrOp = op;
      instrAddr = ad;
      instrImm = imm;
      n = 0;
      while (instrReady !== 1'b1 && n < 4) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] v);
      ex(OP_MOV_IMM, 8'h00, v);
      ex(OP_MOV_TO_MEM, ad, 8'h00);
   endtask
   // returns {carry, memory, acc}
   function automatic logic [16:0] model(input mcuop_op_e op, input logic [7:0] a,
      input logic [7:0] m, input logic c);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, ~m} + {8'h00, c};
      case (op)
         OP_MOV_IMM: return {c, m, m};
         OP_MOV_TO_MEM: return {c, a, a};
         OP_OR_MEM, OP_OR_IMM: return {c, m, a | m};
         OP_OR_TO_MEMORY: return {c, a | m, a};
         OP_ROTATE_LEFT: return {c, m[6:0], m[7], a};
         OP_ROTATE_LEFT_TO_ACC: return {c, m, m[6:0], m[7]};
         OP_ROTATE_LEFT_THROUGH_CARRY: return {m[7], m[6:0], c, a};
         OP_ROTATE_LEFT_CARRY_TO_ACC: return {m[7], m, m[6:0], c};
         OP_ROTATE_RIGHT: return {c, m[0], m[7:1], a};
         OP_ROTATE_RIGHT_TO_ACC: return {c, m, m[0], m[7:1]};
         OP_ROTATE_RIGHT_THROUGH_CARRY: return {m[0], c, m[7:1], a};
         OP_ROTATE_RIGHT_CARRY_TO_ACC: return {m[0], m, c, m[7:1]};
         OP_SUBTRACT_WITH_BORROW: return {s[8], m, s[7:0]};
         OP_SUBTRACT_BORROW_TO_MEMORY: return {s[8], s[7:0], a};
         OP_DECREMENT_SKIP_IF_ZERO: return {c, m - 8'h01, a};
         OP_DECREMENT_TO_ACC_SKIP_IF_ZERO: return {c, m, m - 8'h01};
         default: return {c, m, a};
      endcase
   endfunction
   task automatic one(input mcuop_op_e op, input logic [7:0] ad, input logic [7:0] a,
      input logic [7:0] b, input logic c);
      logic [16:0] e;
      logic [7:0] m;
      logic [7:0] s;
      logic [4:0] n;
      m = (ad < DEPTH) ? b : 8'h00;
      e = model(op, a, m, c);
      s = a + ~m + {7'h00, c};
      n = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c};
      wr(8'h00, {c, 7'h2A});
      ex(OP_ROTATE_LEFT_THROUGH_CARRY, 8'h00, 8'h00);
      chkf(carryFlag, c);
      wr(ad, b);
      ex(OP_MOV_IMM, 8'h00, a);
      ex(op, ad, m);
      chkv({4'h0, acc}, {4'h0, e[7:0]});
      chkf(carryFlag, e[16]);
      chkf(discardNext, op inside {5'h13, 5'h14} && m == 8'h01);
      if (op inside {5'h11, 5'h12}) chkf(zeroFlag, s == 8'h00);
      if (op inside {5'h11, 5'h12}) chkf(auxCarryFlag, n[4]);
      if (op inside {5'h11, 5'h12}) chkf(overflowFlag, (a[7] != m[7]) && (s[7] != a[7]));
      ex(OP_MOV_IMM, 8'h00, 8'h00);
      ex(OP_OR_MEM, ad, 8'h00);
      // writes beyond the memory are dropped, so the byte reads back as zero
      chkv({4'h0, acc}, {4'h0, (ad < DEPTH) ? e[15:8] : 8'h00});
   endtask
   initial begin
      #100000;
      mismatches++;
      end_of_test();
   end
   initial begin
      logic [11:0] p;
      logic [7:0] q;
      void'($urandom(78));
      repeat (8) @(posedge sys_clk);
      #1 rstn = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      for (int i = 0; i < 21; i++) begin
         if (i inside {6, 7, 8}) continue;
         one(mcuop_op_e'(i), 8'h9F, 8'h00, 8'h01, 1'b1);
         one(mcuop_op_e'(i), 8'hA0, 8'h5A, 8'hFF, 1'b0);
         repeat (3) one(mcuop_op_e'(i), 8'($urandom), 8'($urandom), 8'($urandom), 1'($urandom));
      end
      p = pc;
      ex(OP_NOP, 8'h00, 8'h00);
      chkv(pc, p + PC_STEP);
      for (int k = 0; k < 3; k++) begin
         p = pc;
         instrTarget = 12'h3C5 + 12'(k);
         ex(OP_CALL, 8'h00, 8'h00);
         intTaken = 1'b1;
         @(posedge sys_clk);
         #1 intTaken = 1'b0;
         q = acc;
         ex(mcuop_op_e'(6 + k), 8'h00, 8'hC3);
         chkv(pc, p + PC_STEP);
         chkv({4'h0, acc}, {4'h0, (k == 1) ? 8'hC3 : q});
         chkf(global_interrupt_enable, k == 2);
      end
      instrValid = 1'b0;
      end_of_test();
   end
endmodule // mcuop_exec_tb
`default_nettype wire
